// file: hw/mbsta_pkg.sv
`default_nettype none
package mbsta_pkg;

	localparam int IR_W   = 8;
	localparam int ID_W   = 32;
	localparam int BSR_W  = 113;

	localparam logic [IR_W-1:0] INS_EXTEST  = 8'h00;
	localparam logic [IR_W-1:0] INS_IDCODE  = 8'h21;
	localparam logic [IR_W-1:0] INS_SAMPLE  = 8'h05;
	localparam logic [IR_W-1:0] INS_CLAMP   = 8'h07;
	localparam logic [IR_W-1:0] INS_HIGHZ   = 8'h03;
	localparam logic [IR_W-1:0] INS_BYPASS  = 8'hFF;

	// Fixed pattern captured into the instruction shifter
	localparam logic [IR_W-1:0] IR_CAPTURE  = 8'h01;
	localparam logic [IR_W-1:0] IR_RESET    = INS_IDCODE;

	// Identification field positions
	localparam int ID_REV_LSB = 28;
	localparam int ID_DEV_LSB = 12;
	localparam int ID_VEN_LSB = 1;
	localparam logic ID_PRESENT = 1'b1;

	typedef enum logic [3:0] {
		ST_RESET, ST_IDLE,
		ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR,
		ST_PAU_DR, ST_EX2_DR, ST_UPD_DR,
		ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR,
		ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
	} mbsta_state_t;

	typedef enum logic [1:0] {
		SEL_BYP, SEL_ID, SEL_BSR
	} mbsta_sel_t;

	// Pin ring: value and active-low output enable per cell
	typedef struct packed {
		logic [BSR_W-1:0] val;
		logic [BSR_W-1:0] oe_n;
	} mbsta_pins_t;

	typedef struct packed {
		mbsta_state_t     st;
		logic             tck_s1;
		logic             tck_s2;
		logic             tck_q;
		logic             tms_s1;
		logic             tms_s2;
		logic             tdi_s1;
		logic             tdi_s2;
		logic [BSR_W-1:0] cap_s1;
		logic [BSR_W-1:0] cap_s2;
		logic [IR_W-1:0]  ir;
		logic [IR_W-1:0]  ir_sh;
		logic [ID_W-1:0]  id_sh;
		logic             byp;
		logic [BSR_W-1:0] bsr_sh;
		logic [BSR_W-1:0] bsr_upd;
		logic             tdo;
		logic             tdo_oe_n;
	} mbsta_regs_t;

endpackage
`default_nettype wire

// file: hw/mbsta_tap.sv
`default_nettype none
module mbsta_tap #(
	parameter logic [3:0]  ID_REV    = 4'h0, // Arbitrary value
	parameter logic [15:0] ID_DEVICE = 16'h1234, // Arbitrary value
	parameter logic [10:0] ID_VENDOR = 11'h2AA // Arbitrary value
) (
	// Clock and reset
	input  wire logic                 core_clk,
	input  wire logic                 rst_n,
	// Test port pins
	input  wire logic                 tck,
	input  wire logic                 tms,
	input  wire logic                 tdi,
	output logic                      tdo,
	output logic                      tdo_oe_n,
	// Pin ring
	input  wire logic [mbsta_pkg::BSR_W-1:0] pin_in,
	input  wire mbsta_pkg::mbsta_pins_t      func_pins,
	output mbsta_pkg::mbsta_pins_t           pins
);

	localparam logic [mbsta_pkg::ID_W-1:0] ID_WORD =
		{ID_REV, ID_DEVICE, ID_VENDOR, mbsta_pkg::ID_PRESENT};

	mbsta_pkg::mbsta_regs_t r;
	mbsta_pkg::mbsta_regs_t n;
	mbsta_pkg::mbsta_sel_t  sel;
	logic                   rise;
	logic                   fall;

	// Unknown codes fall back to bypass so a stray code is harmless
	always_comb begin
		case (r.ir)
			mbsta_pkg::INS_EXTEST: sel = mbsta_pkg::SEL_BSR;
			mbsta_pkg::INS_SAMPLE: sel = mbsta_pkg::SEL_BSR;
			mbsta_pkg::INS_IDCODE: sel = mbsta_pkg::SEL_ID;
			mbsta_pkg::INS_CLAMP:  sel = mbsta_pkg::SEL_BYP;
			mbsta_pkg::INS_HIGHZ:  sel = mbsta_pkg::SEL_BYP;
			mbsta_pkg::INS_BYPASS: sel = mbsta_pkg::SEL_BYP;
			default:               sel = mbsta_pkg::SEL_BYP;
		endcase
	end

	assign rise = r.tck_s2 & ~r.tck_q;
	assign fall = ~r.tck_s2 & r.tck_q;

	always_comb begin
		n = r;
		n.tck_s1 = tck;
		n.tck_s2 = r.tck_s1;
		n.tck_q  = r.tck_s2;
		n.tms_s1 = tms;
		n.tms_s2 = r.tms_s1;
		n.tdi_s1 = tdi;
		n.tdi_s2 = r.tdi_s1;
		n.cap_s1 = pin_in;
		n.cap_s2 = r.cap_s1;
		if (rise) begin
			case (r.st)
				mbsta_pkg::ST_RESET: begin
					n.ir = mbsta_pkg::IR_RESET;
				end
				mbsta_pkg::ST_CAP_DR: begin
					case (sel)
						mbsta_pkg::SEL_BSR: n.bsr_sh = r.cap_s2;
						mbsta_pkg::SEL_ID:  n.id_sh = ID_WORD;
						default:            n.byp = 1'b0;
					endcase
				end
				mbsta_pkg::ST_SH_DR: begin
					case (sel)
						// Cell 1 sits at bit 0 and leaves first
						mbsta_pkg::SEL_BSR: n.bsr_sh =
							{r.tdi_s2, r.bsr_sh[mbsta_pkg::BSR_W-1:1]};
						mbsta_pkg::SEL_ID:  n.id_sh =
							{r.tdi_s2, r.id_sh[mbsta_pkg::ID_W-1:1]};
						default:            n.byp = r.tdi_s2;
					endcase
				end
				mbsta_pkg::ST_UPD_DR: begin
					if (sel == mbsta_pkg::SEL_BSR) begin
						n.bsr_upd = r.bsr_sh;
					end
				end
				mbsta_pkg::ST_CAP_IR: begin
					n.ir_sh = mbsta_pkg::IR_CAPTURE;
				end
				mbsta_pkg::ST_SH_IR: begin
					n.ir_sh = {r.tdi_s2, r.ir_sh[mbsta_pkg::IR_W-1:1]};
				end
				mbsta_pkg::ST_UPD_IR: begin
					n.ir = r.ir_sh;
				end
				default: begin
				end
			endcase
			case (r.st)
				mbsta_pkg::ST_RESET:  n.st = r.tms_s2 ?
					mbsta_pkg::ST_RESET : mbsta_pkg::ST_IDLE;
				mbsta_pkg::ST_IDLE:   n.st = r.tms_s2 ?
					mbsta_pkg::ST_SEL_DR : mbsta_pkg::ST_IDLE;
				mbsta_pkg::ST_SEL_DR: n.st = r.tms_s2 ?
					mbsta_pkg::ST_SEL_IR : mbsta_pkg::ST_CAP_DR;
				mbsta_pkg::ST_CAP_DR: n.st = r.tms_s2 ?
					mbsta_pkg::ST_EX1_DR : mbsta_pkg::ST_SH_DR;
				mbsta_pkg::ST_SH_DR:  n.st = r.tms_s2 ?
					mbsta_pkg::ST_EX1_DR : mbsta_pkg::ST_SH_DR;
				mbsta_pkg::ST_EX1_DR: n.st = r.tms_s2 ?
					mbsta_pkg::ST_UPD_DR : mbsta_pkg::ST_PAU_DR;
				mbsta_pkg::ST_PAU_DR: n.st = r.tms_s2 ?
					mbsta_pkg::ST_EX2_DR : mbsta_pkg::ST_PAU_DR;
				mbsta_pkg::ST_EX2_DR: n.st = r.tms_s2 ?
					mbsta_pkg::ST_UPD_DR : mbsta_pkg::ST_SH_DR;
				mbsta_pkg::ST_UPD_DR: n.st = r.tms_s2 ?
					mbsta_pkg::ST_SEL_DR : mbsta_pkg::ST_IDLE;
				mbsta_pkg::ST_SEL_IR: n.st = r.tms_s2 ?
					mbsta_pkg::ST_RESET : mbsta_pkg::ST_CAP_IR;
				mbsta_pkg::ST_CAP_IR: n.st = r.tms_s2 ?
					mbsta_pkg::ST_EX1_IR : mbsta_pkg::ST_SH_IR;
				mbsta_pkg::ST_SH_IR:  n.st = r.tms_s2 ?
					mbsta_pkg::ST_EX1_IR : mbsta_pkg::ST_SH_IR;
				mbsta_pkg::ST_EX1_IR: n.st = r.tms_s2 ?
					mbsta_pkg::ST_UPD_IR : mbsta_pkg::ST_PAU_IR;
				mbsta_pkg::ST_PAU_IR: n.st = r.tms_s2 ?
					mbsta_pkg::ST_EX2_IR : mbsta_pkg::ST_PAU_IR;
				mbsta_pkg::ST_EX2_IR: n.st = r.tms_s2 ?
					mbsta_pkg::ST_UPD_IR : mbsta_pkg::ST_SH_IR;
				mbsta_pkg::ST_UPD_IR: n.st = r.tms_s2 ?
					mbsta_pkg::ST_SEL_DR : mbsta_pkg::ST_IDLE;
				default:              n.st = mbsta_pkg::ST_RESET;
			endcase
		end
		// The serial output only moves on the falling test clock edge
		if (fall) begin
			n.tdo_oe_n = 1'b1;
			n.tdo      = 1'b0;
			if (r.st == mbsta_pkg::ST_SH_IR) begin
				n.tdo_oe_n = 1'b0;
				n.tdo      = r.ir_sh[0];
			end else if (r.st == mbsta_pkg::ST_SH_DR) begin
				n.tdo_oe_n = 1'b0;
				case (sel)
					mbsta_pkg::SEL_BSR: n.tdo = r.bsr_sh[0];
					mbsta_pkg::SEL_ID:  n.tdo = r.id_sh[0];
					default:            n.tdo = r.byp;
				endcase
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			r          <= '0;
			r.st       <= mbsta_pkg::ST_RESET;
			r.ir       <= mbsta_pkg::IR_RESET;
			r.tdo_oe_n <= 1'b1;
		end else begin
			r <= n;
		end
	end

	// Ring drive: functional paths pass through except under clamp
	// and high impedance, so memory use continues under other codes
	always_comb begin
		pins = func_pins;
		if (r.ir == mbsta_pkg::INS_CLAMP) begin
			pins.val  = r.bsr_upd;
			pins.oe_n = '0;
		end else if (r.ir == mbsta_pkg::INS_HIGHZ) begin
			pins.oe_n = '1;
		end
	end

	assign tdo      = r.tdo;
	assign tdo_oe_n = r.tdo_oe_n;

endmodule
`default_nettype wire

// file: dv/mbsta_tap_properties.sv
`default_nettype none
module mbsta_tap_properties (
	// Watched ports
	input wire logic                   core_clk,
	input wire logic                   rst_n,
	input wire logic                   tck,
	input wire logic                   tdo,
	input wire logic                   tdo_oe_n,
	input wire mbsta_pkg::mbsta_pins_t func_pins,
	input wire mbsta_pkg::mbsta_pins_t pins
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	sequence s_clamped;
		pins.oe_n == '0 && func_pins.oe_n != '0;
	endsequence
	a_tdo_quiet: assert property (tdo_oe_n |-> !tdo)
		else $error("tdo high while disabled");
	a_tdo_on_low: assert property ($changed(tdo) |-> !tck)
		else $error("tdo moved while tck high");
	a_tdo_holds: assert property (
		$changed(tdo) |=> $stable(tdo) [*3])
		else $error("tdo did not hold");
	a_oe_holds: assert property (
		$changed(tdo_oe_n) |=> $stable(tdo_oe_n) [*3])
		else $error("tdo enable did not hold");
	a_pins_normal: assert property (
		pins.oe_n != '0 && pins.oe_n != '1 |-> pins == func_pins)
		else $error("pins differ from normal drive");
	a_highz_val: assert property (
		pins.oe_n == '1 |-> pins.val == func_pins.val)
		else $error("high impedance value differs");
	a_clamp_steady: assert property (
		s_clamped ##1 s_clamped |-> $stable(pins.val))
		else $error("clamped value moved");
	a_reset_normal: assert property ($rose(rst_n) |-> pins == func_pins)
		else $error("pins not normal after reset");
endmodule
bind mbsta_tap mbsta_tap_properties u_props (.core_clk, .rst_n, .tck, .tdo,
	.tdo_oe_n, .func_pins, .pins);
`default_nettype wire

// file: dv/mbsta_ctl.sv
`default_nettype none
module mbsta_ctl (
	// Link
	output logic    tck,
	output logic    tms,
	output logic    tdi,
	input wire logic tdo
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		tck = 0;
		tms = 1;
		tdi = 0;
	end
	// Inputs set while tck low, tdo taken just before the rise
	task automatic xfer(input logic m, input logic d, output logic q);
		tms = m;
		tdi = d;
		#160;
		q = tdo;
		tck = 1;
		#160;
		tck = 0;
	endtask
	// Idle to shift, n bits LSB first, update, back to idle
	task automatic scan(input logic ir, input logic [127:0] din,
		input int n, output logic [127:0] dout);
		logic q;
		dout = '0;
		xfer(1, 0, q);
		if (ir) xfer(1, 0, q);
		xfer(0, 0, q);
		xfer(0, 0, q);
		for (int i = 0; i < n; i++) xfer(i == n - 1, din[i], dout[i]);
		xfer(1, 0, q);
		xfer(0, 0, q);
		// Released line must not look like held data
		tdi = ~tdi;
	endtask
endmodule
`default_nettype wire

// file: dv/memory_boundary_scan_tap_tb.sv
`default_nettype none
module memory_boundary_scan_tap_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [31:0] ID = {4'h0, 16'h1234, 11'h2AA, 1'b1};
	logic core_clk, rst_n, tck, tms, tdi, tdo, tdo_oe_n;
	logic [mbsta_pkg::BSR_W-1:0] pin_in;
	mbsta_pkg::mbsta_pins_t func_pins, pins, ep;
	int miscompares, n_compared, cyc, len;
	logic [127:0] d, q, upd;
	logic [255:0] r;
	// Controller keeps to defined codes; extest repeats after idcode
	logic [7:0] codes [7] = '{8'h00, 8'h05, 8'h07, 8'h03,
		8'hFF, 8'h21, 8'h00};
	initial begin
		core_clk = 0;
		forever #20 core_clk = ~core_clk;
	end
	mbsta_tap i_dut (.core_clk, .rst_n, .tck, .tms, .tdi, .tdo, .tdo_oe_n,
		.pin_in, .func_pins, .pins);
	mbsta_ctl u_ctl (.tck, .tms, .tdi, .tdo);
	task automatic chk(input string what, input logic [255:0] e, g);
		n_compared++;
		if (e !== g) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, e, g);
		end
	endtask
	function automatic int exp_len(input logic [7:0] c);
		return (c == 8'h00 || c == 8'h05) ? 113 : (c == 8'h21) ? 32 : 1;
	endfunction
	task automatic finish_test;
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 30000) begin
			miscompares++;
			finish_test;
		end
	end
	initial begin
		{pin_in, func_pins, rst_n, miscompares, n_compared, cyc, upd} = '0;
		void'($urandom(32'h25843BAE));
		repeat (5) @(posedge core_clk);
		#3 rst_n = 1;
		repeat (5) u_ctl.xfer(1, 0, q[0]);
		u_ctl.xfer(0, 0, q[0]);
		u_ctl.scan(0, '0, 32, q);
		chk("reset idcode", ID, q[31:0]);
		foreach (codes[k]) begin
			for (int j = 0; j < 8; j++) r[j*32 +: 32] = $urandom;
			@(posedge core_clk);
			#3 func_pins = r[225:0];
			pin_in = r[255:143];
			for (int j = 0; j < 4; j++) d[j*32 +: 32] = $urandom;
			u_ctl.scan(1, {120'h0, codes[k]}, 8, q);
			chk("ir capture", 8'h01, q[7:0]);
			len = exp_len(codes[k]);
			u_ctl.scan(0, d, len + 8, q);
			chk("capture", len == 113 ? pin_in : len == 32 ? ID : 0,
				q & ((128'h1 << len) - 1));
			chk("path length", d[7:0], q[len +: 8]);
			if (len == 113) upd = d >> 8;
			ep = func_pins;
			if (codes[k] == 8'h07) ep = {upd[112:0], 113'h0};
			if (codes[k] == 8'h03) ep.oe_n = '1;
			chk("pins", ep, pins);
			chk("tdo enable idle", 1, tdo_oe_n);
		end
		finish_test;
	end
endmodule
`default_nettype wire
